// ---- verilog/cnm_pkg.sv ----
// shared constants and types for the complement/negate/modulo datapath
package cnm_pkg;
  localparam logic [7:0] OP_COMPLEMENT_MOVE_BYTE     = 8'h8b;
  localparam logic [7:0] OP_COMPLEMENT_MOVE_HALF     = 8'h8a;
  localparam logic [7:0] OP_COMPLEMENT_MOVE_WORD     = 8'h88;
  localparam logic [7:0] OP_NEGATE_MOVE_BYTE         = 8'h8f;
  localparam logic [7:0] OP_NEGATE_MOVE_HALF         = 8'h8e;
  localparam logic [7:0] OP_NEGATE_MOVE_WORD         = 8'h8c;
  localparam logic [7:0] OP_REMAINDER_TWO_ADDR_BYTE  = 8'ha7;
  localparam logic [7:0] OP_REMAINDER_TWO_ADDR_HALF  = 8'ha6;
  localparam logic [7:0] OP_REMAINDER_TWO_ADDR_WORD  = 8'ha4;

  localparam logic [5:0]  DIV_CNT_LOAD = 6'h20;
  localparam logic [5:0]  DIV_CNT_LAST = 6'h01;
  localparam logic [31:0] MIN_BYTE     = 32'hffffff80;
  localparam logic [31:0] MIN_HALF     = 32'hffff8000;
  localparam logic [31:0] MIN_WORD     = 32'h80000000;
  localparam logic [31:0] MASK_BYTE    = 32'h000000ff;
  localparam logic [31:0] MASK_HALF    = 32'h0000ffff;
  localparam logic [31:0] MASK_WORD    = 32'hffffffff;
  localparam logic [31:0] RESULT_RST   = 32'h00000000;

  typedef enum logic [2:0] {
    SZ_BYTE = 3'b001,
    SZ_HALF = 3'b010,
    SZ_WORD = 3'b100
  } cnm_size_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } cnm_state_t;
endpackage : cnm_pkg

// ---- verilog/cnm_div_if.sv ----
// handshake between the datapath and its remainder unit
`timescale 1ns/1ns
interface cnm_div_if;
  logic        start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic [31:0] rem;
  logic        done;
  modport ctl  (output start, output dividend, output divisor, input rem, input done);
  modport unit (input start, input dividend, input divisor, output rem, output done);
endinterface : cnm_div_if

// ---- verilog/cnm_rem_unit.sv ----
// unsigned restoring remainder unit, one quotient bit per cycle
`timescale 1ns/1ns
module cnm_rem_unit
  import cnm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  cnm_div_if.unit  div
);
  logic [5:0]  cnt_r;
  logic [5:0]  cnt_nxt;
  logic [31:0] rem_r;
  logic [31:0] rem_nxt;
  logic [31:0] quo_r;
  logic [31:0] quo_nxt;
  logic [31:0] dvs_r;
  logic [31:0] dvs_nxt;
  logic        done_r;
  logic        done_nxt;
  logic [32:0] trial;
  logic [32:0] diff;

  always_comb begin
    trial    = {rem_r, quo_r[31]};
    diff     = trial - {1'b0, dvs_r};
    cnt_nxt  = cnt_r;
    rem_nxt  = rem_r;
    quo_nxt  = quo_r;
    dvs_nxt  = dvs_r;
    done_nxt = 1'b0;
    if (div.start) begin
      rem_nxt = 32'h00000000;
      quo_nxt = div.dividend;
      dvs_nxt = div.divisor;
      cnt_nxt = DIV_CNT_LOAD;
    end else if (cnt_r != 6'h00) begin
      // borrow out of diff means the trial is below the divisor: keep it
      quo_nxt  = {quo_r[30:0], 1'b0};
      rem_nxt  = diff[32] ? trial[31:0] : diff[31:0];
      cnt_nxt  = cnt_r - 6'h01;
      done_nxt = (cnt_r == DIV_CNT_LAST);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r  <= 6'h00;
      rem_r  <= 32'h00000000;
      quo_r  <= 32'h00000000;
      dvs_r  <= 32'h00000000;
      done_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      rem_r  <= rem_nxt;
      quo_r  <= quo_nxt;
      dvs_r  <= dvs_nxt;
      done_r <= done_nxt;
    end
  end

  assign div.rem  = rem_r;
  assign div.done = done_r;

  a_rem_below_div: assert property (@(posedge clk) disable iff (!rst_n)
    done_r |-> rem_r < dvs_r) else $error("remainder not below divisor");
endmodule : cnm_rem_unit

// ---- verilog/cnm_alu.sv ----
// complement-move, negate-move and two-address remainder datapath
`timescale 1ns/1ns
module cnm_alu
  import cnm_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        REQ_VALID,
  input  wire logic [7:0]  OPCODE,
  input  wire logic [31:0] SRC,
  input  wire logic [31:0] DST_IN,
  input  wire logic        DST_LITERAL,
  output logic             READY,
  output logic             DONE,
  output logic             WRITE_EN,
  output logic [31:0]      RESULT,
  output logic             FLAG_N,
  output logic             FLAG_Z,
  output logic             FLAG_C,
  output logic             FLAG_V,
  output logic             EXC_ILLEGAL_OPERAND,
  output logic             EXC_ZERO_DIVIDE,
  output logic             EXC_INT_OVERFLOW,
  output logic             EXC_BAD_OPCODE
);
  cnm_div_if div ();

  cnm_state_t  state_r;
  cnm_state_t  state_nxt;
  cnm_size_t   sz_r;
  cnm_size_t   sz_nxt;
  logic        ready_r;
  logic        ready_nxt;
  logic        done_r;
  logic        done_nxt;
  logic        wr_r;
  logic        wr_nxt;
  logic [31:0] res_r;
  logic [31:0] res_nxt;
  logic        n_r;
  logic        n_nxt;
  logic        z_r;
  logic        z_nxt;
  logic        c_r;
  logic        c_nxt;
  logic        v_r;
  logic        v_nxt;
  logic        ill_r;
  logic        ill_nxt;
  logic        zdv_r;
  logic        zdv_nxt;
  logic        ovf_r;
  logic        ovf_nxt;
  logic        bad_r;
  logic        bad_nxt;
  logic        start_r;
  logic        start_nxt;
  logic [31:0] dvd_r;
  logic [31:0] dvd_nxt;
  logic [31:0] dvs_r;
  logic [31:0] dvs_nxt;
  logic        sign_r;
  logic        sign_nxt;
  logic        mod_done_r;
  logic        mod_done_nxt;

  logic        accept;
  logic        is_cmp;
  logic        is_neg;
  logic        is_mod;
  cnm_size_t   sz;
  logic [31:0] src_s;
  logic [31:0] dst_s;
  logic [31:0] cmp_res;
  logic [31:0] neg_res;
  logic [31:0] size_min;
  logic [31:0] size_mask;
  logic [31:0] rem_s;
  logic [31:0] rem_t;

  function automatic logic [31:0] sext(input logic [31:0] v, input cnm_size_t s);
    case (s)
      SZ_BYTE: sext = {{24{v[7]}}, v[7:0]};
      SZ_HALF: sext = {{16{v[15]}}, v[15:0]};
      default: sext = v;
    endcase
  endfunction : sext

  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? (32'h00000000 - v) : v;
  endfunction : mag

  assign accept = REQ_VALID && ready_r;

  always_comb begin
    is_cmp = 1'b0;
    is_neg = 1'b0;
    is_mod = 1'b0;
    sz     = SZ_WORD;
    case (OPCODE)
      OP_COMPLEMENT_MOVE_BYTE: begin
        is_cmp = 1'b1;
        sz     = SZ_BYTE;
      end
      OP_COMPLEMENT_MOVE_HALF: begin
        is_cmp = 1'b1;
        sz     = SZ_HALF;
      end
      OP_COMPLEMENT_MOVE_WORD: begin
        is_cmp = 1'b1;
      end
      OP_NEGATE_MOVE_BYTE: begin
        is_neg = 1'b1;
        sz     = SZ_BYTE;
      end
      OP_NEGATE_MOVE_HALF: begin
        is_neg = 1'b1;
        sz     = SZ_HALF;
      end
      OP_NEGATE_MOVE_WORD: begin
        is_neg = 1'b1;
      end
      OP_REMAINDER_TWO_ADDR_BYTE: begin
        is_mod = 1'b1;
        sz     = SZ_BYTE;
      end
      OP_REMAINDER_TWO_ADDR_HALF: begin
        is_mod = 1'b1;
        sz     = SZ_HALF;
      end
      OP_REMAINDER_TWO_ADDR_WORD: begin
        is_mod = 1'b1;
      end
      default: begin
        is_cmp = 1'b0;
      end
    endcase
  end

  // operands are signed at the selected size; results come out sign-extended
  always_comb begin
    src_s     = sext(SRC, sz);
    dst_s     = sext(DST_IN, sz);
    cmp_res   = ~src_s;
    neg_res   = sext(32'h00000000 - src_s, sz);
    size_min  = (sz == SZ_BYTE) ? MIN_BYTE : (sz == SZ_HALF) ? MIN_HALF : MIN_WORD;
    size_mask = (sz == SZ_BYTE) ? MASK_BYTE : (sz == SZ_HALF) ? MASK_HALF : MASK_WORD;
    rem_s     = sign_r ? (32'h00000000 - div.rem) : div.rem;
    rem_t     = sext(rem_s, sz_r);
  end

  always_comb begin
    state_nxt    = state_r;
    sz_nxt       = sz_r;
    done_nxt     = 1'b0;
    wr_nxt       = 1'b0;
    res_nxt      = res_r;
    n_nxt        = n_r;
    z_nxt        = z_r;
    c_nxt        = c_r;
    v_nxt        = v_r;
    ill_nxt      = 1'b0;
    zdv_nxt      = 1'b0;
    ovf_nxt      = 1'b0;
    bad_nxt      = 1'b0;
    start_nxt    = 1'b0;
    dvd_nxt      = dvd_r;
    dvs_nxt      = dvs_r;
    sign_nxt     = sign_r;
    mod_done_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          done_nxt = 1'b1;
          if (!(is_cmp || is_neg || is_mod)) begin
            bad_nxt = 1'b1;
          end else if (DST_LITERAL) begin
            ill_nxt = 1'b1;
          end else if (is_cmp) begin
            wr_nxt  = 1'b1;
            res_nxt = cmp_res;
            n_nxt   = cmp_res[31];
            z_nxt   = (cmp_res == 32'h00000000);
            c_nxt   = 1'b0;
            v_nxt   = 1'b0; // inverting a sized value never needs truncation
          end else if (is_neg) begin
            wr_nxt  = 1'b1;
            res_nxt = neg_res;
            n_nxt   = neg_res[31];
            z_nxt   = (neg_res == 32'h00000000);
            c_nxt   = 1'b0;
            v_nxt   = (src_s == size_min);
          end else if (src_s == 32'h00000000) begin
            zdv_nxt = 1'b1;
          end else begin
            // divide magnitudes, then restore the dividend's sign
            done_nxt  = 1'b0;
            start_nxt = 1'b1;
            dvd_nxt   = mag(dst_s);
            dvs_nxt   = mag(src_s);
            sign_nxt  = dst_s[31];
            sz_nxt    = sz;
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (div.done) begin
          done_nxt     = 1'b1;
          wr_nxt       = 1'b1;
          mod_done_nxt = 1'b1;
          res_nxt      = rem_t;
          n_nxt        = rem_t[31];
          z_nxt        = (rem_t == 32'h00000000);
          c_nxt        = 1'b0;
          v_nxt        = (rem_t != rem_s);
          ovf_nxt      = (rem_t != rem_s);
          state_nxt    = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    ready_nxt = (state_nxt == ST_IDLE);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_r    <= ST_IDLE;
      sz_r       <= SZ_WORD;
      ready_r    <= 1'b0;
      done_r     <= 1'b0;
      wr_r       <= 1'b0;
      res_r      <= RESULT_RST;
      n_r        <= 1'b0;
      z_r        <= 1'b0;
      c_r        <= 1'b0;
      v_r        <= 1'b0;
      ill_r      <= 1'b0;
      zdv_r      <= 1'b0;
      ovf_r      <= 1'b0;
      bad_r      <= 1'b0;
      start_r    <= 1'b0;
      dvd_r      <= RESULT_RST;
      dvs_r      <= RESULT_RST;
      sign_r     <= 1'b0;
      mod_done_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      sz_r       <= sz_nxt;
      ready_r    <= ready_nxt;
      done_r     <= done_nxt;
      wr_r       <= wr_nxt;
      res_r      <= res_nxt;
      n_r        <= n_nxt;
      z_r        <= z_nxt;
      c_r        <= c_nxt;
      v_r        <= v_nxt;
      ill_r      <= ill_nxt;
      zdv_r      <= zdv_nxt;
      ovf_r      <= ovf_nxt;
      bad_r      <= bad_nxt;
      start_r    <= start_nxt;
      dvd_r      <= dvd_nxt;
      dvs_r      <= dvs_nxt;
      sign_r     <= sign_nxt;
      mod_done_r <= mod_done_nxt;
    end
  end

  assign div.start    = start_r;
  assign div.dividend = dvd_r;
  assign div.divisor  = dvs_r;

  cnm_rem_unit u_rem (
    .clk   (CLK),
    .rst_n (RST_N),
    .div   (div)
  );

  assign READY               = ready_r;
  assign DONE                = done_r;
  assign WRITE_EN            = wr_r;
  assign RESULT              = res_r;
  assign FLAG_N              = n_r;
  assign FLAG_Z              = z_r;
  assign FLAG_C              = c_r;
  assign FLAG_V              = v_r;
  assign EXC_ILLEGAL_OPERAND = ill_r;
  assign EXC_ZERO_DIVIDE     = zdv_r;
  assign EXC_INT_OVERFLOW    = ovf_r;
  assign EXC_BAD_OPCODE      = bad_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_cmp_inverts: assert property (
    accept && is_cmp && !DST_LITERAL |=> DONE && WRITE_EN && ((RESULT ^ $past(src_s)) == 32'hffffffff))
    else $error("complement result wrong");
  a_neg_sums_zero: assert property (
    accept && is_neg && !DST_LITERAL |=> WRITE_EN && (((RESULT + $past(src_s)) & $past(size_mask)) == 32'h0))
    else $error("negate result wrong");
  a_write_flags: assert property (
    DONE && WRITE_EN |-> FLAG_N == RESULT[31] && FLAG_Z == (RESULT == 32'h0) && !FLAG_C)
    else $error("N, Z or C flag wrong");
  a_cmp_no_ovf: assert property (
    accept && is_cmp && !DST_LITERAL |=> !FLAG_V) else $error("complement set V");
  a_neg_ovf: assert property (
    accept && is_neg && !DST_LITERAL |=> FLAG_V == ($past(src_s) == $past(size_min)))
    else $error("negate V flag wrong");
  a_illegal_dst: assert property (
    accept && (is_cmp || is_neg || is_mod) && DST_LITERAL |=> DONE && EXC_ILLEGAL_OPERAND && !WRITE_EN)
    else $error("illegal operand not raised");
  a_zero_div: assert property (
    accept && is_mod && !DST_LITERAL && src_s == 32'h0 |=> DONE && EXC_ZERO_DIVIDE && !WRITE_EN)
    else $error("zero divide not raised");
  a_mod_latency: assert property (
    accept && is_mod && !DST_LITERAL && src_s != 32'h0 |=> !READY ##34 DONE && WRITE_EN && READY)
    else $error("remainder latency wrong");
  a_rem_sign: assert property (
    mod_done_r |-> RESULT == 32'h0 || RESULT[31] == sign_r) else $error("remainder sign wrong");
  a_mod_ovf: assert property (
    mod_done_r |-> EXC_INT_OVERFLOW == FLAG_V) else $error("overflow exception mismatch");

  c_cmp_done: cover property (accept && is_cmp && !DST_LITERAL ##1 DONE);
  c_neg_ovf:  cover property (DONE && WRITE_EN && FLAG_V);
  c_mod_neg:  cover property (mod_done_r && FLAG_N);
  c_zdiv:     cover property (EXC_ZERO_DIVIDE);
endmodule : cnm_alu

// ---- sim/cnm_decoder_model.sv ----
// far-side model: decoder that hands operands to the datapath
`timescale 1ns/1ns
module cnm_decoder_model (
  input  wire logic        clk,
  input  wire logic        ready,
  output logic             req_valid,
  output logic [7:0]       opcode,
  output logic [31:0]      src,
  output logic [31:0]      dst_in,
  output logic             dst_literal
);
  logic busy;
  initial begin
    busy = 1'b0;
    req_valid = 1'b0;
    {opcode, src, dst_in, dst_literal} = '0;
  end
  // idle operands keep flipping, so sampling them off the accepting edge gives a wrong result
  always @(posedge clk) begin
    #1;
    if (!busy) {opcode, src, dst_in, dst_literal} = ~{opcode, src, dst_in, dst_literal};
  end
  // request stands until an edge sees ready high, which also allows back-to-back requests
  task automatic issue(input logic [7:0] op, input logic [31:0] s, input logic [31:0] d, input logic lit);
    busy = 1'b1;
    #1;
    req_valid = 1'b1;
    {opcode, src, dst_in, dst_literal} = {op, s, d, lit};
    do @(posedge clk); while (ready !== 1'b1);
  endtask : issue
  task automatic release_bus;
    #1;
    req_valid = 1'b0;
    busy = 1'b0;
  endtask : release_bus
endmodule : cnm_decoder_model

// ---- sim/test_cnm_alu.sv ----
// self-checking bench for the complement/negate/remainder datapath
`timescale 1ns/1ns
module test_cnm_alu;
  import cnm_pkg::*;
  typedef struct packed {
    logic [31:0] when;
    logic [4:0]  exc;
    logic [3:0]  nzcv;
    logic [31:0] res;
  } cnm_note_t;
  localparam int LIMIT = 20000;
  // clk starts low in its declaration: setting it in a process would give a false negedge at time zero
  logic        clk = 1'b0, rst_n = 1'b0, req_valid, dst_literal, ready, done, write_en;
  logic        fn, fz, fc, fv, e_ill, e_zd, e_ovf, e_bad;
  logic [7:0]  opcode;
  logic [31:0] src, dst_in, result;
  logic [31:0] exp_res = '0;
  logic [3:0]  exp_nzcv = '0;
  logic [31:0] cyc = '0;
  int          fails = 0;
  int          check_count = 0;
  cnm_note_t   notes[$];
  logic [7:0]  ops [10] = '{OP_COMPLEMENT_MOVE_BYTE, OP_COMPLEMENT_MOVE_HALF, OP_COMPLEMENT_MOVE_WORD,
                            OP_NEGATE_MOVE_BYTE, OP_NEGATE_MOVE_HALF, OP_NEGATE_MOVE_WORD,
                            OP_REMAINDER_TWO_ADDR_BYTE, OP_REMAINDER_TWO_ADDR_HALF,
                            OP_REMAINDER_TWO_ADDR_WORD, 8'h87};
  logic [31:0] mins [3] = '{MIN_BYTE, MIN_HALF, MIN_WORD};

  cnm_alu DUT (.CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .OPCODE(opcode), .SRC(src),
    .DST_IN(dst_in), .DST_LITERAL(dst_literal), .READY(ready), .DONE(done), .WRITE_EN(write_en),
    .RESULT(result), .FLAG_N(fn), .FLAG_Z(fz), .FLAG_C(fc), .FLAG_V(fv), .EXC_ILLEGAL_OPERAND(e_ill),
    .EXC_ZERO_DIVIDE(e_zd), .EXC_INT_OVERFLOW(e_ovf), .EXC_BAD_OPCODE(e_bad));
  cnm_decoder_model far_end (.clk(clk), .ready(ready), .req_valid(req_valid), .opcode(opcode),
    .src(src), .dst_in(dst_in), .dst_literal(dst_literal));

  always #4 clk = ~clk;

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  function automatic logic [31:0] sx(input logic [31:0] v, input int sz);
    case (sz)
      0: return {{24{v[7]}}, v[7:0]};
      1: return {{16{v[15]}}, v[15:0]};
      default: return v;
    endcase
  endfunction : sx

  // i picks the table entry: group is i/3, size is i%3, entry 9 is an unknown opcode
  task automatic run_op(input int i, input logic [31:0] s, input logic [31:0] d, input logic lit);
    logic signed [31:0] a, b, r;
    logic               v, bad, zd, wr;
    cnm_note_t          n;
    a = sx(d, i % 3);
    b = sx(s, i % 3);
    v = 1'b0;
    bad = (i == 9);
    zd = (i / 3 == 2) && !bad && !lit && (b == 0);
    wr = !bad && !lit && !zd;
    case (i / 3)
      0: r = sx(~s, i % 3);
      1: begin
        r = sx(-b, i % 3);
        v = (b == mins[i % 3]);
      end
      default: r = (b == 0 || b == -1) ? '0 : sx(a % b, i % 3);
    endcase
    if (wr) begin
      exp_res = r;
      exp_nzcv = {r[31], r == 0, 1'b0, v};
    end
    far_end.issue(ops[i], s, d, lit);
    // cyc is read at the accepting edge, before that edge's increment lands
    n.when = cyc + ((i / 3 == 2 && wr) ? 35 : 1);
    n.exc = {wr, bad, lit && !bad, zd, 1'b0};
    n.nzcv = exp_nzcv;
    n.res = exp_res;
    notes.push_back(n);
  endtask : run_op

  always @(negedge clk) begin
    cnm_note_t n;
    if (done === 1'b1) begin
      if (notes.size() == 0) check("unexpected answer", 1, 0);
      else begin
        n = notes.pop_front();
        check("answer cycle", cyc, n.when);
        check("result", result, n.res);
        check("flags", {fn, fz, fc, fv}, n.nzcv);
        check("exceptions", {write_en, e_bad, e_ill, e_zd, e_ovf}, n.exc);
      end
    end else check("idle pulses", {write_en, e_bad, e_ill, e_zd, e_ovf}, '0);
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    void'($urandom(49198));
    repeat (10) @(posedge clk);
    @(negedge clk);
    check("reset state", {ready, done, write_en, result}, '0);
    @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    run_op(2, 32'h12345678, 32'h0, 1'b0);
    run_op(3, 32'h01234567, 32'h0, 1'b0);
    for (int j = 0; j < 3; j++) begin
      run_op(j, 32'hffffffff, 32'h0, 1'b0);
      run_op(3 + j, mins[j], 32'h0, 1'b0);
      run_op(3 * j + 1, 32'h5, 32'h0, 1'b1);
      run_op(6 + j, 32'h2, 32'hfffffff9, 1'b0);
      run_op(6 + j, 32'hfffffffe, 32'h7, 1'b0);
      run_op(6 + j, 32'hffffffff, mins[j], 1'b0);
      run_op(6 + j, (j == 2) ? 32'h0 : 32'h1 << (8 * (j + 1)), 32'h5, 1'b0);
    end
    run_op(9, 32'h1, 32'h1, 1'b1);
    for (int k = 0; k < 300; k++) begin
      run_op($urandom % 10, ($urandom % 4 == 0) ? $urandom % 3 - 1 : $urandom, $urandom, $urandom % 8 == 0);
    end
    run_op(8, 32'h7, 32'h64, 1'b0);
    far_end.release_bus();
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    notes.delete();
    exp_res = '0;
    exp_nzcv = '0;
    @(negedge clk);
    check("mid-run reset", {ready, result, fn, fz, fc, fv}, '0);
    @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    run_op(5, 32'h1, 32'h0, 1'b0);
    run_op(7, 32'h3, 32'hffff8001, 1'b0);
    far_end.release_bus();
    repeat (40) @(posedge clk);
    check("pending answers", notes.size(), 0);
    print_verdict();
  end
endmodule : test_cnm_alu
